// ==== dv/csr_core_props.sv ====
// Assertion checker for the CPU special register set
`timescale 1ns/100ps
module csr_core_props (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] instruction_counter,
	input wire [4:0] bank_base,
	input wire [7:0] push_addr,
	input wire [7:0] push_data,
	input wire push_we
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	rdata_upper_a: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0) else $error("read upper bits set");
	bank_write_a: assert property ($changed(bank_base) |->
		$rose(s_axi_bvalid)) else $error("bank changed without a write");
	push_bytes_a: assert property ($rose(push_we) |->
		push_data == instruction_counter[7:0] ##1 push_we &&
		push_data == instruction_counter[15:8] &&
		push_addr == $past(push_addr) + 8'h01) else $error("push order wrong");
	push_pair_a: assert property (push_we ##1 push_we |=> !push_we)
		else $error("push too long");
	reset_start_a: assert property ($rose(aresetn) |->
		instruction_counter == 16'h0000) else $error("counter not cleared");
endmodule // csr_core_props
bind csr_core csr_core_props csr_core_props_inst (.*);

// ==== dv/csr_core_tb.sv ====
// Self-checking testbench for the CPU special register set
`timescale 1ns/100ps
module csr_core_tb;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, push_we, ta, tw, tb;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, push_addr, push_data;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] instruction_counter;
	logic [4:0] bank_base;
	logic [15:0] pq[$];
	int mismatches = 0, checked = 0, cyc = 0;
	logic [23:0] rows[9] = '{
		24'h00A5A5,
		24'h043C3C,
		24'h0C3030,
		24'h10FF01,
		24'h141111,
		24'h100000,
		24'h142222,
		24'h100301,
		24'h081818};
	csr_core csr_core_inst (.*);
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (push_we === 1'b1)
			pq.push_back({push_addr, push_data});
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task summarize();
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e, input string n);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task wr(input [7:0] a, input [7:0] d, input [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			if (tb)
				chk(s_axi_bresp, r, "bresp");
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tb)
				s_axi_bready <= 1'b0;
		end while (!tb);
	endtask
	task rd(input [7:0] a, input [7:0] e, input [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tb = s_axi_rvalid;
			if (tb) begin
				chk(s_axi_rdata, {24'h0, e}, "rdata");
				chk(s_axi_rresp, r, "rresp");
			end
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			if (tb)
				s_axi_rready <= 1'b0;
		end while (!tb);
	endtask
	task op(input [7:0] code);
		wr(8'h28, code);
		wr(8'h2C, 8'h01);
	endtask
	initial begin
		rst();
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		rd(8'h14, 8'h11);
		chk(bank_base, 5'h18, "bank");
		rst();
		rd(8'h0C, 8'h07);
		rd(8'h08, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h1C, 8'h00);
		rd(8'h20, 8'h00);
		chk(instruction_counter, 16'h0000, "pc");
		wr(8'h00, 8'h88);
		wr(8'h04, 8'h88);
		op(8'h00);
		rd(8'h00, 8'h10);
		rd(8'h08, 8'hC5);
		op(8'h02);
		rd(8'h00, 8'h87);
		rd(8'h08, 8'hC4);
		wr(8'h00, 8'h10);
		wr(8'h04, 8'h10);
		op(8'h03);
		rd(8'h04, 8'h01);
		rd(8'h00, 8'h00);
		rd(8'h08, 8'h44);
		wr(8'h00, 8'h07);
		wr(8'h08, 8'h00);
		rd(8'h08, 8'h01);
		wr(8'h04, 8'h09);
		op(8'h00);
		rd(8'h00, 8'h10);
		rd(8'h08, 8'h41);
		op(8'h04);
		rd(8'h00, 8'h01);
		rd(8'h04, 8'h07);
		wr(8'h04, 8'h00);
		op(8'h04);
		rd(8'h00, 8'h01);
		rd(8'h08, 8'h45);
		op(8'h05);
		rd(8'h00, 8'h02);
		rd(8'h08, 8'h45);
		wr(8'h08, 8'h80);
		op(8'h01);
		rd(8'h00, 8'h03);
		rd(8'h08, 8'h00);
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 8'hEE);
		s_axi_wstrb <= 4'hF;
		rd(8'h00, 8'h03);
		wr(8'h30, 8'h55, 2'h2);
		rd(8'h30, 8'h00, 2'h2);
		wr(8'h0C, 8'h30);
		wr(8'h1C, 8'h34);
		wr(8'h20, 8'h12);
		pq.delete();
		wr(8'h2C, 8'h02);
		repeat (4) @(posedge aclk);
		chk(pq.size(), 2, "pushes");
		chk(pq[0], 16'h3134, "push low");
		chk(pq[1], 16'h3212, "push high");
		rd(8'h0C, 8'h32);
		wr(8'h24, 8'h8F);
		wr(8'h2C, 8'h04);
		rd(8'h0C, 8'h07);
		chk(instruction_counter, 16'h3C00, "alt pc");
		wr(8'h24, 8'h0F);
		wr(8'h2C, 8'h04);
		chk(instruction_counter, 16'h0000, "pc");
		summarize();
	end
endmodule // csr_core_tb

// ==== logic/csr_core.v ====
// CPU special register set with an AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "csr_map.vh"

// Behaviour
// - The 16-bit counter is mapped at 1CH (low) and 20H (high), resets to 0000H.
// - With the alternate start enabled, a control-word reload restarts at that vector.
// - Status bit 7 records carry or borrow of an arithmetic operation.
// - Status bit 6 records the low-nibble carry or borrow.
// - Status bits 4-3 pick the working bank at 00H, 08H, 10H or 18H.
// - Status bit 2 records signed overflow of an arithmetic result.
// - Status bit 0 is read-only odd parity of the accumulator.
// - Stack pointer: 8 bits, reset 07H, so the first push lands at 08H.
// - A push stores counter low at pointer+1, high at +2, then adds two.
// - Two 16-bit data pointers share addresses; select bit 0 picks one.
// - Select register bits 7-1 read zero and ignore writes.
// - Helper keeps mul/div operands and results and is the second add/subtract operand.
// - The accumulator feeds the ALU and receives its result.
// - Select 0 reaches the first data pointer, select 1 the second.
module csr_core (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [15:0] instruction_counter,
	output wire [4:0] bank_base,
	output wire [7:0] push_addr,
	output wire [7:0] push_data,
	output wire push_we
);

	function mapped;
		input [7:0] a;
		begin
			mapped = (a <= `CSR_OFF_CTL) && (a[1:0] == 2'h0);
		end
	endfunction

	// Push sequencer states
	localparam PUSH_IDLE = 2'h0;
	localparam PUSH_LOW = 2'h1;
	localparam PUSH_HIGH = 2'h2;

	// Core registers
	reg [7:0] acc_reg;
	reg [7:0] help_reg;
	reg [7:0] psw_reg;
	reg [7:0] stk_reg;
	reg psel_reg;
	reg [7:0] ptr_lo_reg [0:1];
	reg [7:0] ptr_hi_reg [0:1];
	reg [15:0] pc_reg;
	reg [7:0] alt_reg;
	reg [2:0] op_reg;

	// Bus channel state
	reg [7:0] awaddr_reg;
	reg aw_have_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_have_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;

	// Push sequencer
	reg [1:0] push_phase_reg;
	reg [7:0] push_addr_reg;
	reg [7:0] push_data_reg;
	reg push_we_reg;
	reg [15:0] push_pc_reg;

	wire parity;
	wire do_write;
	wire [7:0] wa;
	wire [7:0] wb;
	wire [15:0] alt_vec;
	wire [15:0] alt_base;
	wire wr_ok;
	wire push_idle;

	// ALU working values
	reg [8:0] sum9;
	reg [4:0] sum5;
	reg [7:0] sum7;
	reg [7:0] opb;
	reg cin;
	reg sub;
	reg [15:0] prod;
	reg [7:0] res_acc;
	reg [7:0] res_help;
	reg [7:0] res_psw;
	reg [31:0] rd;

	assign parity = ^acc_reg;
	assign wa = awaddr_reg;
	assign wb = wdata_reg[7:0];
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_ok = do_write && wstrb_reg[0];
	assign push_idle = (push_phase_reg == PUSH_IDLE);

	// Bus outputs
	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign instruction_counter = pc_reg;
	assign bank_base = {psw_reg[`CSR_PSW_RS_HI:`CSR_PSW_RS_LO],
		3'h0};
	assign push_addr = push_addr_reg;
	assign push_data = push_data_reg;
	assign push_we = push_we_reg;
	assign alt_base = {2'h0, alt_reg[`CSR_ALT_ADR_HI:0], 10'h000};
	assign alt_vec = alt_reg[`CSR_ALT_EN] ? alt_base : `CSR_RST_PC;

	// ALU operating through the accumulator and helper register
	always @* begin
		sub = (op_reg == `CSR_OP_SUBB);
		cin = (op_reg == `CSR_OP_ADD) ? 1'b0 : psw_reg[`CSR_PSW_CY];
		opb = sub ? ~help_reg : help_reg;
		if (op_reg == `CSR_OP_INC) begin
			opb = 8'h01;
			cin = 1'b0;
		end
		// Subtraction adds the inverted operand
		sum9 = {1'b0, acc_reg} + {1'b0, opb} + {8'h00, cin ^ sub};
		// Nibble and seven-bit sums give half carry and overflow
		sum5 = {1'b0, acc_reg[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin ^ sub};
		sum7 = {1'b0, acc_reg[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin ^ sub};
		// Multiply and divide work through the helper register
		prod = acc_reg * help_reg;
		res_acc = sum9[7:0];
		res_help = help_reg;
		res_psw = psw_reg;
		res_psw[`CSR_PSW_CY] = sum9[8] ^ sub;
		res_psw[`CSR_PSW_AC] = sum5[4] ^ sub;
		res_psw[`CSR_PSW_OV] = sum9[8] ^ sum7[7];
		if (op_reg == `CSR_OP_MUL) begin
			res_acc = prod[7:0];
			res_help = prod[15:8];
			res_psw[`CSR_PSW_CY] = 1'b0;
			res_psw[`CSR_PSW_OV] = (prod[15:8] != 8'h00);
			res_psw[`CSR_PSW_AC] = psw_reg[`CSR_PSW_AC];
		end else if (op_reg == `CSR_OP_DIV) begin
			res_psw[`CSR_PSW_CY] = 1'b0;
			res_psw[`CSR_PSW_AC] = psw_reg[`CSR_PSW_AC];
			// Divide by zero flags overflow and keeps the accumulator
			res_psw[`CSR_PSW_OV] = (help_reg == 8'h00);
			if (help_reg != 8'h00) begin
				res_acc = acc_reg / help_reg;
				res_help = acc_reg % help_reg;
			end else begin
				res_acc = acc_reg;
			end
		end else if (op_reg == `CSR_OP_INC) begin
			// Increment leaves every flag alone
			res_psw = psw_reg;
		end
	end

	// Read data mux
	always @* begin
		rd = 32'h0000_0000;
		// Unmapped offsets read as zero
		if (s_axi_araddr == `CSR_OFF_ACC) begin
			rd[7:0] = acc_reg;
		end else if (s_axi_araddr == `CSR_OFF_HELP) begin
			rd[7:0] = help_reg;
		end else if (s_axi_araddr == `CSR_OFF_PSW) begin
			rd[7:0] = {psw_reg[7:1], parity};
		end else if (s_axi_araddr == `CSR_OFF_STK) begin
			rd[7:0] = stk_reg;
		end else if (s_axi_araddr == `CSR_OFF_PSEL) begin
			rd[7:0] = {7'h00, psel_reg};
		end else if (s_axi_araddr == `CSR_OFF_PTRL) begin
			rd[7:0] = ptr_lo_reg[psel_reg];
		end else if (s_axi_araddr == `CSR_OFF_PTRH) begin
			rd[7:0] = ptr_hi_reg[psel_reg];
		end else if (s_axi_araddr == `CSR_OFF_CNTL) begin
			rd[7:0] = pc_reg[7:0];
		end else if (s_axi_araddr == `CSR_OFF_CNTH) begin
			rd[7:0] = pc_reg[15:8];
		end else if (s_axi_araddr == `CSR_OFF_ALT) begin
			rd[7:0] = alt_reg;
		end else if (s_axi_araddr == `CSR_OFF_OP) begin
			rd[7:0] = {5'h00, op_reg};
		end else if (s_axi_araddr == `CSR_OFF_CTL) begin
			rd[7:0] = {6'h00, !push_idle, 1'b0};
		end
	end

	// AXI channel handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CSR_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `CSR_RESP_OKAY;
		end else begin
			// Address and data are taken in either order
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= mapped(wa) ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			// A read answer stands until it is taken
			if (s_axi_arvalid && !rvalid_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd;
				rresp_reg <= mapped(s_axi_araddr) ? `CSR_RESP_OKAY :
					`CSR_RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Core registers, software writes and control actions
	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg <= 8'h00;
			help_reg <= 8'h00;
			psw_reg <= `CSR_RST_PSW;
			stk_reg <= `CSR_RST_STK;
			psel_reg <= 1'b0;
			ptr_lo_reg[0] <= 8'h00;
			ptr_lo_reg[1] <= 8'h00;
			ptr_hi_reg[0] <= 8'h00;
			ptr_hi_reg[1] <= 8'h00;
			pc_reg <= `CSR_RST_PC;
			alt_reg <= `CSR_RST_ALT;
			op_reg <= `CSR_OP_ADD;
			push_phase_reg <= PUSH_IDLE;
			push_addr_reg <= 8'h00;
			push_data_reg <= 8'h00;
			push_we_reg <= 1'b0;
			push_pc_reg <= 16'h0000;
		end else begin
			push_we_reg <= 1'b0;
			// Low byte goes out first, then the high byte
			case (push_phase_reg)
				PUSH_LOW: begin
					push_addr_reg <= stk_reg + 8'h01;
					push_data_reg <= push_pc_reg[7:0];
					push_we_reg <= 1'b1;
					push_phase_reg <= PUSH_HIGH;
				end
				PUSH_HIGH: begin
					push_addr_reg <= stk_reg + 8'h02;
					push_data_reg <= push_pc_reg[15:8];
					push_we_reg <= 1'b1;
					stk_reg <= stk_reg + 8'h02;
					push_phase_reg <= PUSH_IDLE;
				end
				default: begin
					push_phase_reg <= PUSH_IDLE;
				end
			endcase
			// Software writes, one register per word
			if (wr_ok) begin
				if (wa == `CSR_OFF_ACC) begin
					acc_reg <= wb;
				end else if (wa == `CSR_OFF_HELP) begin
					help_reg <= wb;
				end else if (wa == `CSR_OFF_PSW) begin
					psw_reg <= {wb[7:1], 1'b0};
				end else if (wa == `CSR_OFF_STK) begin
					if (push_idle) begin
						stk_reg <= wb;
					end
				end else if (wa == `CSR_OFF_PSEL) begin
					psel_reg <= wb[0];
				end else if (wa == `CSR_OFF_PTRL) begin
					ptr_lo_reg[psel_reg] <= wb;
				end else if (wa == `CSR_OFF_PTRH) begin
					ptr_hi_reg[psel_reg] <= wb;
				end else if (wa == `CSR_OFF_CNTL) begin
					pc_reg[7:0] <= wb;
				end else if (wa == `CSR_OFF_CNTH) begin
					pc_reg[15:8] <= wb;
				end else if (wa == `CSR_OFF_ALT) begin
					alt_reg <= {wb[7], 3'h0, wb[3:0]};
				end else if (wa == `CSR_OFF_OP) begin
					op_reg <= wb[2:0];
				end else if (wa == `CSR_OFF_CTL) begin
					// Control word: execute, push, reload
					if (wb[`CSR_CTL_START]) begin
						acc_reg <= res_acc;
						help_reg <= res_help;
						psw_reg <= {res_psw[7:1], 1'b0};
					end
					if (wb[`CSR_CTL_PUSH] && push_idle) begin
						push_pc_reg <= pc_reg;
						push_phase_reg <= PUSH_LOW;
					end
					if (wb[`CSR_CTL_RELOAD]) begin
						pc_reg <= alt_vec;
						stk_reg <= `CSR_RST_STK;
					end
				end
			end
		end
	end

endmodule // csr_core

// ==== logic/csr_map.vh ====
// Register map, field positions and reset values of the CPU special register set
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
`define CSR_OFF_ACC 8'h00
`define CSR_OFF_HELP 8'h04
`define CSR_OFF_PSW 8'h08
`define CSR_OFF_STK 8'h0C
`define CSR_OFF_PSEL 8'h10
`define CSR_OFF_PTRL 8'h14
`define CSR_OFF_PTRH 8'h18
`define CSR_OFF_CNTL 8'h1C
`define CSR_OFF_CNTH 8'h20
`define CSR_OFF_ALT 8'h24
`define CSR_OFF_OP 8'h28
`define CSR_OFF_CTL 8'h2C
`define CSR_PSW_CY 7
`define CSR_PSW_AC 6
`define CSR_PSW_F0 5
`define CSR_PSW_RS_HI 4
`define CSR_PSW_RS_LO 3
`define CSR_PSW_OV 2
`define CSR_PSW_F1 1
`define CSR_PSW_P 0
`define CSR_ALT_EN 7
`define CSR_ALT_ADR_HI 3
`define CSR_RST_PC 16'h0000
`define CSR_RST_STK 8'h07
`define CSR_RST_PSW 8'h00
`define CSR_RST_PSEL 8'h00
`define CSR_RST_ALT 8'h00
`define CSR_OP_ADD 3'h0
`define CSR_OP_ADDC 3'h1
`define CSR_OP_SUBB 3'h2
`define CSR_OP_MUL 3'h3
`define CSR_OP_DIV 3'h4
`define CSR_OP_INC 3'h5
`define CSR_CTL_START 0
`define CSR_CTL_PUSH 1
`define CSR_CTL_RELOAD 2
`define CSR_RESP_OKAY 2'h0
`define CSR_RESP_SLVERR 2'h2
`endif
